// File: include/bir_regs_map.vh
`ifndef BIR_REGS_MAP_VH
`define BIR_REGS_MAP_VH

// Register offsets on the host register port
`define BIR_OFS_MODE   8'h00
`define BIR_OFS_PTR    8'h01
`define BIR_OFS_ADDR   8'h02
`define BIR_OFS_COUNT  8'h03
`define BIR_OFS_DATA0  8'h04
`define BIR_OFS_DATA1  8'h05
`define BIR_OFS_DATA2  8'h06
`define BIR_OFS_DATA3  8'h07
`define BIR_OFS_REV    8'h08
`define BIR_OFS_BATCH  8'h09
`define BIR_OFS_SLICE  8'h0a
`define BIR_OFS_DIE_LO 8'h0b
`define BIR_OFS_DIE_HI 8'h0c
`define BIR_OFS_CAUSE  8'h0d
`define BIR_OFS_SEC    8'h0e

// Field positions
`define BIR_SLICE_MSB  4
`define BIR_DIE_MSB    10
`define BIR_SEC_MSB    6
`define BIR_CAUSE_MSB  3
`define BIR_ADR_MSB    7
`define BIR_ADR_LSB    1

// Transfer mode codes
`define BIR_MODE_CUR   8'h01
`define BIR_MODE_PRD   8'h02
`define BIR_MODE_PWR   8'h04

// Status codes
`define BIR_STAT_OK    8'h00
`define BIR_STAT_BUSY  8'h01
`define BIR_STAT_FAIL  8'h03

// Reset values
`define BIR_RST_BYTE   8'h00
`define BIR_RST_COUNT  8'h01
`define BIR_RST_CAUSE  4'h0
`define BIR_RST_SEC    7'h00

// Timing: shortest bit time and core clock rate
`define BIR_BIT_NS     10000
`define BIR_CLK_MHZ    125
`define BIR_CAP_WAIT   2'h3

`endif

// File: logic/bir_skid_buf.v
`timescale 1ns/1ps
module bir_skid_buf #(
  parameter W = 10
) (
  // Clock and reset
  input  wire         core_clk,
  input  wire         arst_n,
  // Filling side
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  // Draining side
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);

  reg [W-1:0] mem_r [0:1];
  reg         wp_r;
  reg         rp_r;
  reg [1:0]   cnt_r;
  wire        push;
  wire        pop;

  // Two slots, honest full and empty
  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage carries no reset, only pointers and fill level do
  always @(posedge core_clk)
  begin
    if (push)
      mem_r[wp_r] <= in_data;
  end

  // Pointers and fill level
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end
    else
    begin
      if (push)
        wp_r <= ~wp_r;
      if (pop)
        rp_r <= ~rp_r;
      if (push & ~pop)
        cnt_r <= cnt_r + 2'h1;
      else if (pop & ~push)
        cnt_r <= cnt_r - 2'h1;
    end
  end

endmodule

// File: logic/bir_regs_top.v
`timescale 1ns/1ps
`include "bir_regs_map.vh"
module bir_regs_top #(
  parameter [7:0]  REV_ID   = 8'h01,   // Arbitrary value
  parameter [7:0]  BATCH_ID = 8'h5a,   // Arbitrary value
  parameter [4:0]  SLICE_ID = 5'h0c,   // Arbitrary value
  parameter [10:0] DIE_ID   = 11'h123  // Arbitrary value
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        arst_n,
  // Host register port
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  output reg         reg_rvalid,
  // Transfer start strobe and status
  input  wire        xfer_start,
  output reg  [7:0]  bridge_status,
  // Restart cause levels and channel flags
  input  wire [3:0]  restart_src,
  input  wire [6:0]  sec_flags_in,
  // Two-wire bus, open drain
  output reg         scl_o,
  output reg         scl_oe,
  input  wire        sda_i,
  output reg         sda_o,
  output reg         sda_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Constants and functions

  // Quarter bit in core cycles, cut to the divider width on purpose
  localparam integer QUARTER_I = (`BIR_BIT_NS * `BIR_CLK_MHZ + 3999) / 4000;
  localparam [8:0]   QUARTER   = QUARTER_I[8:0];

  localparam [4:0] S_IDLE  = 5'h01;
  localparam [4:0] S_START = 5'h02;
  localparam [4:0] S_BYTE  = 5'h04;
  localparam [4:0] S_PUSH  = 5'h08;
  localparam [4:0] S_STOP  = 5'h10;

  localparam [1:0] G_ADR  = 2'h0;
  localparam [1:0] G_PTR  = 2'h1;
  localparam [1:0] G_ADR2 = 2'h2;
  localparam [1:0] G_DATA = 2'h3;

  // Target address byte with direction bit
  function [7:0] adr_byte;
    input [7:0] adr;
    input       rd;
    begin
      adr_byte = {adr[`BIR_ADR_MSB:`BIR_ADR_LSB], rd};
    end
  endfunction

  // Keep the lowest cause if several arrive together
  function [3:0] lowest_one;
    input [3:0] v;
    begin
      lowest_one = v & (~v + 4'h1);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  reg [7:0] mode_r;
  reg [7:0] ptr_r;
  reg [7:0] adr_r;
  reg [7:0] count_r;
  reg [7:0] data_r [0:3];
  reg [3:0] cause_r;
  reg [6:0] sec_r;
  reg [3:0] src_s1_r;
  reg [3:0] src_s2_r;
  reg [1:0] cap_cnt_r;
  reg       cap_done_r;
  reg       sda_s1_r;
  reg       sda_s2_r;

  reg [4:0] st_r;
  reg [8:0] div_r;
  reg [1:0] q_r;
  reg [3:0] bit_r;
  reg [7:0] sh_r;
  reg [1:0] seg_r;
  reg [1:0] byte_r;
  reg       rx_r;
  reg       fail_r;

  wire       busy;
  wire       tick;
  wire       last;
  wire       host_data_wr;
  wire       buf_in_ready;
  wire       buf_out_valid;
  wire [9:0] buf_out_data;
  wire       cfg_ok;

  assign busy = (st_r != S_IDLE);
  assign tick = busy & (div_r == QUARTER - 9'h1);
  assign last = (byte_r == count_r[1:0] - 2'h1);
  assign host_data_wr = reg_wr & (reg_addr >= `BIR_OFS_DATA0) & (reg_addr <= `BIR_OFS_DATA3);
  assign cfg_ok = ((mode_r == `BIR_MODE_CUR) | (mode_r == `BIR_MODE_PRD) |
                   (mode_r == `BIR_MODE_PWR)) &
                  (count_r >= 8'h01) & (count_r <= 8'h04);

  ////////////////////////////////////////////////////////////////////////////
  // Received bytes wait here while the host writes a data byte

  bir_skid_buf #(
    .W (10)
  ) u_rx_buf (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .in_valid  (st_r == S_PUSH),
    .in_ready  (buf_in_ready),
    .in_data   ({byte_r, sh_r}),
    .out_valid (buf_out_valid),
    .out_ready (~host_data_wr),
    .out_data  (buf_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Host writes; bridge setup frozen while busy

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_r    <= `BIR_RST_BYTE;
      ptr_r     <= `BIR_RST_BYTE;
      adr_r     <= `BIR_RST_BYTE;
      count_r   <= `BIR_RST_COUNT;
      data_r[0] <= `BIR_RST_BYTE;
      data_r[1] <= `BIR_RST_BYTE;
      data_r[2] <= `BIR_RST_BYTE;
      data_r[3] <= `BIR_RST_BYTE;
    end
    else
    begin
      if (reg_wr & ~busy)
      begin
        case (reg_addr)
          `BIR_OFS_MODE:  mode_r  <= reg_wdata;
          `BIR_OFS_PTR:   ptr_r   <= reg_wdata;
          `BIR_OFS_ADDR:  adr_r   <= reg_wdata;
          `BIR_OFS_COUNT: count_r <= reg_wdata;
          default: ;
        endcase
      end
      if (host_data_wr)
        data_r[reg_addr[1:0]] <= reg_wdata;
      else if (buf_out_valid)
        data_r[buf_out_data[9:8]] <= buf_out_data[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads, answered one cycle later; unmapped reads zero

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
      begin
        case (reg_addr)
          `BIR_OFS_MODE:   reg_rdata <= mode_r;
          `BIR_OFS_PTR:    reg_rdata <= ptr_r;
          `BIR_OFS_ADDR:   reg_rdata <= adr_r;
          `BIR_OFS_COUNT:  reg_rdata <= count_r;
          `BIR_OFS_DATA0,
          `BIR_OFS_DATA1,
          `BIR_OFS_DATA2,
          `BIR_OFS_DATA3:  reg_rdata <= data_r[reg_addr[1:0]];
          `BIR_OFS_REV:    reg_rdata <= REV_ID;
          `BIR_OFS_BATCH:  reg_rdata <= BATCH_ID;
          `BIR_OFS_SLICE:  reg_rdata <= {3'h0, SLICE_ID};
          `BIR_OFS_DIE_LO: reg_rdata <= DIE_ID[7:0];
          `BIR_OFS_DIE_HI: reg_rdata <= {5'h00, DIE_ID[`BIR_DIE_MSB:8]};
          `BIR_OFS_CAUSE:  reg_rdata <= {4'h0, cause_r};
          `BIR_OFS_SEC:    reg_rdata <= {1'b0, sec_r};
          default:         reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Restart cause: sync the levels, catch once after reset release

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      src_s1_r   <= `BIR_RST_CAUSE;
      src_s2_r   <= `BIR_RST_CAUSE;
      cap_cnt_r  <= 2'h0;
      cap_done_r <= 1'b0;
      cause_r    <= `BIR_RST_CAUSE;
      sec_r      <= `BIR_RST_SEC;
    end
    else
    begin
      src_s1_r <= restart_src;
      src_s2_r <= src_s1_r;
      sec_r    <= sec_flags_in;
      // Wait for the synchroniser to fill before sampling
      if (cap_cnt_r != `BIR_CAP_WAIT)
        cap_cnt_r <= cap_cnt_r + 2'h1;
      else if (!cap_done_r)
      begin
        cap_done_r <= 1'b1;
        cause_r    <= lowest_one(src_s2_r);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus input sync and quarter-bit divider

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      div_r    <= 9'h000;
    end
    else
    begin
      sda_s1_r <= sda_i;
      sda_s2_r <= sda_s1_r;
      // Quarter rounded up keeps the bit rate at or below the limit
      if (!busy || tick)
        div_r <= 9'h000;
      else
        div_r <= div_r + 9'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bridge sequencer

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r          <= S_IDLE;
      q_r           <= 2'h0;
      bit_r         <= 4'h0;
      sh_r          <= 8'h00;
      seg_r         <= G_ADR;
      byte_r        <= 2'h0;
      rx_r          <= 1'b0;
      fail_r        <= 1'b0;
      bridge_status <= `BIR_STAT_OK;
      scl_o         <= 1'b0;
      scl_oe        <= 1'b0;
      sda_o         <= 1'b0;
      sda_oe        <= 1'b0;
    end
    else
    begin
      if (tick)
        q_r <= q_r + 2'h1;
      case (st_r)
        S_IDLE:
        begin
          q_r <= 2'h0;
          if (xfer_start)
          begin
            if (cfg_ok)
            begin
              bridge_status <= `BIR_STAT_BUSY;
              st_r   <= S_START;
              seg_r  <= G_ADR;
              byte_r <= 2'h0;
              fail_r <= 1'b0;
            end
            else
              bridge_status <= `BIR_STAT_FAIL;
          end
        end
        // Start, also used as repeated start
        S_START:
        begin
          if (tick)
          begin
            case (q_r)
              2'h0: begin scl_oe <= 1'b1; sda_oe <= 1'b0; end
              2'h1: scl_oe <= 1'b0;
              2'h2: sda_oe <= 1'b1;
              default:
              begin
                scl_oe <= 1'b1;
                st_r   <= S_BYTE;
                bit_r  <= 4'h0;
                rx_r   <= 1'b0;
                sh_r   <= adr_byte(adr_r, (seg_r == G_ADR2) |
                                   (mode_r == `BIR_MODE_CUR));
              end
            endcase
          end
        end
        // Eight data bits then the acknowledge bit
        S_BYTE:
        begin
          if (tick)
          begin
            case (q_r)
              2'h0:
              begin
                scl_oe <= 1'b1;
                if (bit_r[3])
                  sda_oe <= rx_r & ~last;
                else
                  sda_oe <= ~rx_r & ~sh_r[7];
              end
              2'h1: ;
              2'h2: scl_oe <= 1'b0;
              default:
              begin
                scl_oe <= 1'b1;
                bit_r  <= bit_r + 4'h1;
                if (!bit_r[3])
                  sh_r <= {sh_r[6:0], sda_s2_r};
                else if (rx_r)
                  st_r <= S_PUSH;
                else if (sda_s2_r)
                begin
                  fail_r <= 1'b1;
                  st_r   <= S_STOP;
                end
                else
                begin
                  bit_r <= 4'h0;
                  case (seg_r)
                    G_ADR:
                    begin
                      if (mode_r == `BIR_MODE_CUR)
                      begin
                        seg_r <= G_DATA;
                        rx_r  <= 1'b1;
                      end
                      else
                      begin
                        seg_r <= G_PTR;
                        sh_r  <= ptr_r;
                      end
                    end
                    G_PTR:
                    begin
                      if (mode_r == `BIR_MODE_PRD)
                      begin
                        seg_r <= G_ADR2;
                        st_r  <= S_START;
                      end
                      else
                      begin
                        seg_r <= G_DATA;
                        sh_r  <= data_r[0];
                      end
                    end
                    G_ADR2:
                    begin
                      seg_r <= G_DATA;
                      rx_r  <= 1'b1;
                    end
                    default:
                    begin
                      if (last)
                        st_r <= S_STOP;
                      else
                      begin
                        byte_r <= byte_r + 2'h1;
                        sh_r   <= data_r[byte_r + 2'h1];
                      end
                    end
                  endcase
                end
              end
            endcase
          end
        end
        // Hand the received byte on; a full buffer holds the bus
        S_PUSH:
        begin
          q_r <= 2'h0;
          if (buf_in_ready)
          begin
            if (last)
              st_r <= S_STOP;
            else
            begin
              st_r   <= S_BYTE;
              bit_r  <= 4'h0;
              byte_r <= byte_r + 2'h1;
            end
          end
        end
        // Stop condition, then report once data has landed
        S_STOP:
        begin
          if (tick)
          begin
            case (q_r)
              2'h0: begin scl_oe <= 1'b1; sda_oe <= 1'b1; end
              2'h1: scl_oe <= 1'b0;
              2'h2: sda_oe <= 1'b0;
              default: q_r <= 2'h3;
            endcase
          end
          else if (q_r == 2'h3 && !buf_out_valid)
          begin
            st_r          <= S_IDLE;
            bridge_status <= fail_r ? `BIR_STAT_FAIL : `BIR_STAT_OK;
          end
        end
        default:
          st_r <= S_IDLE;
      endcase
    end
  end

endmodule

// File: sim/bir_regs_chk.sv
`timescale 1ns/1ps
`include "bir_regs_map.vh"
module bir_regs_chk #(
  parameter [7:0]  REV_ID   = 8'h01,
  parameter [7:0]  BATCH_ID = 8'h5a,
  parameter [4:0]  SLICE_ID = 5'h0c,
  parameter [10:0] DIE_ID   = 11'h123
) (
  // Clock and reset
  input wire       core_clk,
  input wire       arst_n,
  // Register port
  input wire       reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_rdata,
  input wire [6:0] sec_flags_in,
  // Bridge
  input wire       xfer_start,
  input wire [7:0] bridge_status,
  input wire       scl_o,
  input wire       scl_oe,
  input wire       sda_o,
  input wire       sda_oe
);
  reg [7:0] id_exp;
  reg       id_hit;

  // Fixed answer per offset; unmapped offsets also read zero
  always @*
  begin
    id_hit = reg_addr > `BIR_OFS_SEC;
    id_exp = 8'h00;
    case (reg_addr)
      `BIR_OFS_REV:    {id_hit, id_exp} = {1'b1, REV_ID};
      `BIR_OFS_BATCH:  {id_hit, id_exp} = {1'b1, BATCH_ID};
      `BIR_OFS_SLICE:  {id_hit, id_exp} = {4'h8, SLICE_ID};
      `BIR_OFS_DIE_LO: {id_hit, id_exp} = {1'b1, DIE_ID[7:0]};
      `BIR_OFS_DIE_HI: {id_hit, id_exp} = {6'h20, DIE_ID[10:8]};
      default:         id_exp = 8'h00;
    endcase
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////
  id_read_a:
    assert property (reg_rd && id_hit |=> reg_rdata == $past(id_exp))
    else $error("identity read mismatch");
  sec_read_a:
    assert property (reg_rd && reg_addr == `BIR_OFS_SEC && $stable(sec_flags_in) && $past(arst_n)
      |=> reg_rdata == {1'b0, $past(sec_flags_in, 2)})
    else $error("channel flags read mismatch");
  cause_onehot_a:
    assert property (reg_rd && reg_addr == `BIR_OFS_CAUSE
      |=> reg_rdata[7:4] == 4'h0 && $countones(reg_rdata) <= 1)
    else $error("restart cause not one-hot");
  status_code_a:
    assert property (bridge_status inside {`BIR_STAT_OK, `BIR_STAT_BUSY, `BIR_STAT_FAIL})
    else $error("illegal status code");
  start_busy_a:
    assert property (xfer_start && bridge_status != `BIR_STAT_BUSY
      |=> bridge_status != `BIR_STAT_OK)
    else $error("start not answered");
  status_hold_a:
    assert property (bridge_status != `BIR_STAT_BUSY && !xfer_start |=> $stable(bridge_status))
    else $error("final status moved");
  bus_idle_a:
    assert property (bridge_status != `BIR_STAT_BUSY |-> !scl_oe && !sda_oe)
    else $error("bus held outside transfer");
  open_drain_a:
    assert property (!scl_o && !sda_o)
    else $error("bus driven high");
endmodule

// File: sim/bir_i2c_target.sv
`timescale 1ns/1ps
module bir_i2c_target #(
  parameter [6:0] TGT_ADR = 7'h50
) (
  // Bus levels
  input wire       scl,
  input wire       sda,
  // Pull data low
  output reg       sda_pull,
  // Scenario controls
  input wire       nack,
  input wire [7:0] rd_byte
);
  reg       act, arm, snd, adr_ph, hit, rw, s;
  reg [3:0] bitc;
  reg [7:0] sh;
  reg [7:0] rx [0:7];
  integer   rx_n;

  initial {act, arm, snd, sda_pull, rx_n} = 0;

  // Start or repeated start: data falls while clock high
  always @(negedge sda)
  if (scl)
    {act, arm, bitc, adr_ph, snd, sda_pull} = {2'b11, 4'h0, 3'b100};

  // Stop: data rises while clock high
  always @(posedge sda)
  if (scl)
    {act, sda_pull} = 2'b00;

  always @(posedge scl) s = sda;

  // Act on falling clock so data is stable while clock is high
  always @(negedge scl)
  if (act && arm)
    arm = 1'b0; // Clock drop that closes the start is no bit
  else if (act)
  begin
    if (bitc < 4'd8)
    begin
      if (!snd)
        sh = {sh[6:0], s};
      bitc = bitc + 4'd1;
      if (bitc == 4'd8 && snd)
        sda_pull = 1'b0;
      else if (bitc == 4'd8)
      begin
        if (adr_ph)
          {hit, rw} = {sh[7:1] == TGT_ADR && !nack, sh[0]};
        adr_ph = 1'b0;
        rx[rx_n[2:0]] = sh;
        rx_n = rx_n + 1;
        sda_pull = hit;
      end
      else if (snd)
        sda_pull = !rd_byte[7 - bitc];
    end
    else
    begin
      bitc = 4'd0;
      snd = snd ? !s : hit && rw;
      sda_pull = snd && !rd_byte[7];
    end
  end
endmodule

// File: sim/bridge_id_reset_status_regs_tb.sv
`timescale 1ns/1ps
`include "bir_regs_map.vh"
module bridge_id_reset_status_regs_tb;
  reg        core_clk, arst_n, reg_wr, reg_rd, xfer_start, nack;
  reg  [7:0] reg_addr, reg_wdata, rd_byte;
  reg  [3:0] restart_src;
  reg  [6:0] sec_flags_in;
  wire [7:0] reg_rdata, bridge_status;
  wire       reg_rvalid, scl_o, scl_oe, sda_o, sda_oe, tgt_pull;
  wire       scl = !scl_oe;
  wire       sda = !(sda_oe || tgt_pull); // Pulled up when released
  integer    fail_count, n_checks, cyc, base, k, i;
  time       t0;

  // Core clock, 8 ns
  initial core_clk = 1'b0;
  always #4 core_clk = ~core_clk;

  bir_regs_top #(.REV_ID(8'h02), .BATCH_ID(8'h3c), .SLICE_ID(5'h15), .DIE_ID(11'h6a5))
  bir_regs_top_i (.core_clk(core_clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .xfer_start(xfer_start), .bridge_status(bridge_status),
    .restart_src(restart_src), .sec_flags_in(sec_flags_in), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));

  bir_i2c_target bir_i2c_target_i (.scl(scl), .sda(sda), .sda_pull(tgt_pull),
    .nack(nack), .rd_byte(rd_byte));

  // Cycle ceiling; all transfers need about 75000 cycles
  always @(posedge core_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 90000)
    begin
      fail_count = fail_count + 1;
      end_sim;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task check(input [7:0] got, input [7:0] exp);
  begin
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  end
  endtask

  task wr(input [7:0] a, input [7:0] d);
  begin
    @(negedge core_clk);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge core_clk);
    reg_wr = 1'b0;
  end
  endtask

  // A missing valid pulse turns the data into a mismatch
  task rd(input [7:0] a, input [7:0] e);
  begin
    @(negedge core_clk);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge core_clk);
    reg_rd = 1'b0;
    check(reg_rvalid === 1'b1 ? reg_rdata : 8'hxx, e);
  end
  endtask

  task reset_dut(input [3:0] src);
  begin
    restart_src = src;
    arst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (5) @(negedge core_clk);
  end
  endtask

  task start(input [7:0] mode, input [7:0] cnt);
  begin
    wr(`BIR_OFS_MODE, mode);
    wr(`BIR_OFS_COUNT, cnt);
    base = bir_i2c_target_i.rx_n;
    @(negedge core_clk);
    xfer_start = 1'b1;
    @(negedge core_clk);
    xfer_start = 1'b0;
  end
  endtask

  // Poll the status until the transfer ends
  task finish(input [7:0] e);
  begin
    for (i = 0; i < 60000 && bridge_status === `BIR_STAT_BUSY; i = i + 1)
      @(negedge core_clk);
    check(bridge_status, e);
    check({6'h00, scl_oe, sda_oe}, 8'h00);
    check({7'h00, bir_i2c_target_i.act}, 8'h00);
  end
  endtask

  ////////////////////////////////////////////////////////////////////////
  task t_ids;
  begin
    rd(`BIR_OFS_CAUSE, 8'h00);
    rd(`BIR_OFS_REV, 8'h02);
    wr(`BIR_OFS_REV, 8'hff);
    rd(`BIR_OFS_REV, 8'h02);
    rd(`BIR_OFS_BATCH, 8'h3c);
    rd(`BIR_OFS_SLICE, 8'h15);
    rd(`BIR_OFS_DIE_LO, 8'ha5);
    rd(`BIR_OFS_DIE_HI, 8'h06);
    rd(8'h0f, 8'h00);
    check(bridge_status, `BIR_STAT_OK);
    $display("test ids done");
  end
  endtask

  // Each cause alone, then two at once keeps the lowest
  task t_cause;
  begin
    for (k = 0; k < 5; k = k + 1)
    begin
      reset_dut(k < 4 ? 4'h1 << k : 4'hc);
      rd(`BIR_OFS_CAUSE, k < 4 ? 8'h01 << k : 8'h04);
    end
    $display("test cause done");
  end
  endtask

  task t_sec;
  begin
    sec_flags_in = 7'h55;
    rd(`BIR_OFS_SEC, 8'h55);
    sec_flags_in = 7'h2a;
    rd(`BIR_OFS_SEC, 8'h2a);
    $display("test flags done");
  end
  endtask

  // Bad mode or count fails at once without touching the bus
  task t_bad;
  begin
    for (k = 0; k < 4; k = k + 1)
    begin
      start(k == 0 ? 8'h03 : k == 3 ? 8'h00 : 8'h01, k == 1 ? 8'h00 : k == 2 ? 8'h05 : 8'h01);
      check(bridge_status, `BIR_STAT_FAIL);
      check({7'h00, scl_oe}, 8'h00);
    end
    $display("test invalid done");
  end
  endtask

  task t_cur_read;
  begin
    wr(`BIR_OFS_ADDR, 8'ha0);
    rd_byte = 8'hc6;
    start(`BIR_MODE_CUR, 8'h01);
    check(bridge_status, `BIR_STAT_BUSY);
    wr(`BIR_OFS_MODE, `BIR_MODE_PWR);
    wr(`BIR_OFS_COUNT, 8'h02);
    xfer_start = 1'b1;
    @(negedge core_clk);
    xfer_start = 1'b0;
    finish(`BIR_STAT_OK);
    rd(`BIR_OFS_MODE, `BIR_MODE_CUR);
    rd(`BIR_OFS_COUNT, 8'h01);
    rd(`BIR_OFS_DATA0, 8'hc6);
    check(bir_i2c_target_i.rx[base], 8'ha1);
    $display("test current read done");
  end
  endtask

  task t_ptr_write;
  begin
    wr(`BIR_OFS_PTR, 8'h12);
    wr(`BIR_OFS_DATA0, 8'h9e);
    start(`BIR_MODE_PWR, 8'h01);
    // Skip the start release, then time one whole data bit
    @(posedge scl);
    @(posedge scl);
    t0 = $time;
    @(posedge scl);
    check({7'h00, ($time - t0) < `BIR_BIT_NS}, 8'h00);
    finish(`BIR_STAT_OK);
    check(bir_i2c_target_i.rx[base], 8'ha0);
    check(bir_i2c_target_i.rx[base + 1], 8'h12);
    check(bir_i2c_target_i.rx[base + 2], 8'h9e);
    $display("test pointer write done");
  end
  endtask

  task t_nack;
  begin
    nack = 1'b1;
    start(`BIR_MODE_PRD, 8'h01);
    finish(`BIR_STAT_FAIL);
    check(bir_i2c_target_i.rx[base], 8'ha0);
    nack = 1'b0;
    $display("test refused address done");
  end
  endtask

  task end_sim;
  begin
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask

  // Main sequence
  initial
  begin
    {reg_wr, reg_rd, xfer_start, nack, reg_addr, reg_wdata, rd_byte} = 0;
    {sec_flags_in, fail_count, n_checks, cyc} = 0;
    reset_dut(4'h0);
    t_ids;
    t_cause;
    t_sec;
    t_bad;
    t_cur_read;
    t_ptr_write;
    t_nack;
    end_sim;
  end
endmodule

bind bir_regs_top bir_regs_chk #(.REV_ID(REV_ID), .BATCH_ID(BATCH_ID), .SLICE_ID(SLICE_ID),
  .DIE_ID(DIE_ID)) bir_regs_chk_i (.core_clk(core_clk), .arst_n(arst_n), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .sec_flags_in(sec_flags_in),
  .xfer_start(xfer_start), .bridge_status(bridge_status), .scl_o(scl_o),
  .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe));
